// [core/flash_cmd_consts.svh]
// constants of the flash command interpreter
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

// opcodes
`define OP_WRAP      8'h77
`define OP_RST_EN    8'h66
`define OP_RST       8'h99
`define OP_DPD       8'hb9
`define OP_RELEASE   8'hab
`define OP_MFR_ID    8'h90
`define OP_QUAD_READ 8'heb

// frame positions in link clocks
`define OPC_CLKS     6'd8
`define WRAP_CLKS    6'd16
`define ID_LAST_CLK  6'd31
`define QADDR_NIBS   6'd6
`define QMODE_HI     6'd6
`define QMODE_LO     6'd7
`define QDATA_START  6'd11

// wrap setting field, stored as bits 6..4 of the byte
`define WRAP_HI      6
`define WRAP_LO      4
`define WRAP_DEFAULT 3'h1
`define CONT_KEEP    2'h2

// timing
`define CLK_MHZ      100
`define TDP_NS       3000
`define RELEASE_WAIT_TIME_NS     3000
`define RELEASE_WITH_ID_WAIT_TIME_NS     1800
`define TDP_CYC      10'((`TDP_NS * `CLK_MHZ) / 1000)
`define RELEASE_WAIT_TIME_CYC    10'((`RELEASE_WAIT_TIME_NS * `CLK_MHZ) / 1000)
`define RELEASE_WITH_ID_WAIT_TIME_CYC    10'((`RELEASE_WITH_ID_WAIT_TIME_NS * `CLK_MHZ) / 1000)

`endif

// [core/flash_cmd_pkg.sv]
// types of the flash command interpreter
package flash_cmd_pkg;
    typedef enum logic [1:0] {
        PWR_ON,
        PWR_ENTER,
        PWR_DOWN,
        PWR_WAKE
    } pwr_state_type;
endpackage

// [core/bit_sync.sv]
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic stage1_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_r <= RESET_VAL;
            q        <= RESET_VAL;
        end else begin
            stage1_r <= d;
            q        <= stage1_r;
        end
    end
endmodule // bit_sync
`default_nettype wire

// [core/wrap_page_ram.sv]
// one page of array data, written on mclk, read on the link clock
`timescale 1ns/1ps
`default_nettype none
module wrap_page_ram (
    input  wire logic       wrClk,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrAddr,
    input  wire logic [7:0] wrData,
    input  wire logic       rdClk,
    input  wire logic [7:0] rdAddr,
    output logic      [7:0] rdData
);
    logic [7:0] mem [0:255];

    always_ff @(posedge wrClk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge rdClk) begin
        rdData <= mem[rdAddr];
    end
endmodule // wrap_page_ram
`default_nettype wire

// [core/flash_cmd_core.sv]
// command interpreter: wrap, software reset, power-down, id reads
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.svh"

// Operation
// - wrapped quad read restarts at aligned section start until cs rises
// - wrap command is 77h, 24 dummy bits, one wrap byte, quad
// - keep only bits 6..4 of wrap byte; bit 4 low enables wrap
// - bits 6..5 pick 8, 16, 32 or 64 byte sections
// - wrap disable bit is set after power-up
// - stored wrap setting applies to every later quad read
// - quad read and wrap command need the quad enable bit
// - software reset stops work and reloads volatile defaults
// - software reset ignored in power-down until release
// - software reset ignored in continuous read mode
// - reset only when 99h directly follows 66h
// - any other command after 66h cancels the reset enable
// - B9h must end right after bit eight; enter power-down after delay
// - in power-down only ABh is recognised
// - device starts in normal mode, never in power-down
// - ABh alone releases power-down after the release time
// - ABh plus three dummy bytes shifts out device id repeatedly
// - ABh ignored while erase, program or write is busy
// - 90h gives manufacturer/device bytes, order set by address bit 0
// - opcode and address sampled on rising edges, msb first
// - continuous read mode skips the opcode on the next frame
module flash_cmd_core
    import flash_cmd_pkg::*;
#(
    parameter logic [7:0] MFR_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] DEV_ID = 8'h3c  // arbitrary value
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       sclk,
    input  wire logic       csN,
    input  wire logic [3:0] ioIn,
    output logic      [3:0] ioOut,
    output logic      [3:0] ioOe,
    input  wire logic       quadEnable,
    input  wire logic       busy,
    input  wire logic       loadValid,
    input  wire logic [7:0] loadAddr,
    input  wire logic [7:0] loadData,
    output logic            softResetPulse,
    output logic            powerDown,
    output logic      [2:0] wrapSetting,
    output logic            contMode
);
    // ----------------------------------------------------------------
    // mclk side state; the held copies stay steady while a frame runs
    // ----------------------------------------------------------------
    pwr_state_type pwr_r;
    logic [9:0]    timer_r;
    logic [2:0]    wrap_r;
    logic          contMode_r;
    logic          rstEn_r;
    logic          softRst_r;
    logic          seenSeq_r;
    logic          csSync;
    logic          csPrev_r;
    logic          frameEnd;
    logic          qeHeld_r;
    logic          busyHeld_r;
    logic          normHeld_r;
    logic          pdnHeld_r;

    // ----------------------------------------------------------------
    // link side frame record; count, opcode, address and tail kept after cs rises
    // ----------------------------------------------------------------
    logic          frameOn_r;
    logic          seq_r;
    logic          contFrame_r;
    logic [5:0]    cnt_r;
    logic [7:0]    opc_r;
    logic [23:0]   addr_r;
    logic [7:0]    tail_r;
    logic [3:0]    outCnt_r;
    logic          idOn_r;
    logic          qOn_r;
    logic          nib_r;
    logic [23:0]   curAddr_r;
    logic [23:0]   curAddrNxt;
    logic [7:0]    rdData;

    logic [5:0]    cntNow;
    logic [7:0]    opcNow;
    logic          contNow;
    logic          inQuad;
    logic [5:0]    qi;
    logic          quadRead;
    logic          quadCmd;
    logic [23:0]   linAddr;
    logic [23:0]   wrapAddr;
    logic [23:0]   wrapMask;
    logic [7:0]    idByte;

    // ----------------------------------------------------------------
    // link clock: frame counting and capture
    // ----------------------------------------------------------------
    assign cntNow  = frameOn_r ? cnt_r : 6'd0;
    assign opcNow  = frameOn_r ? opc_r : 8'h00;
    assign contNow = frameOn_r ? contFrame_r : contMode_r;
    // opcode skipped in continuous read mode
    assign inQuad  = contNow || (cntNow >= `OPC_CLKS);
    assign qi      = contNow ? cntNow : cntNow - `OPC_CLKS;
    assign quadCmd = inQuad && qeHeld_r && normHeld_r
                   && (contNow || opcNow == `OP_QUAD_READ
                       || opcNow == `OP_WRAP);
    assign quadRead = quadCmd && (contNow || opcNow == `OP_QUAD_READ);

    // frame ends on cs rise; next frame starts fresh
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            frameOn_r <= 1'b0;
        end else begin
            frameOn_r <= 1'b1;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            seq_r       <= 1'b0;
            contFrame_r <= 1'b0;
            cnt_r       <= 6'd0;
            opc_r       <= 8'h00;
        end else begin
            if (!frameOn_r) begin
                seq_r       <= ~seq_r;
                contFrame_r <= contMode_r;
            end
            if (cntNow != 6'h3f) begin
                cnt_r <= cntNow + 6'd1;
            end
            // opcode msb first on rising edges
            if (!contNow && cntNow < `OPC_CLKS) begin
                opc_r <= {opcNow[6:0], ioIn[0]};
            end else begin
                opc_r <= opcNow;
            end
        end
    end

    always_ff @(posedge sclk) begin
        // single-bit address of 90h, frozen once id output starts
        if (!contNow && opcNow == `OP_MFR_ID && cntNow <= `ID_LAST_CLK) begin
            addr_r <= {addr_r[22:0], ioIn[0]};
        end else if (quadCmd && qi < `QADDR_NIBS) begin
            addr_r <= {addr_r[19:0], ioIn};
        end
        if (quadCmd && (qi == `QMODE_HI || qi == `QMODE_LO)) begin
            tail_r <= {tail_r[3:0], ioIn};
        end
    end

    // ----------------------------------------------------------------
    // link clock: id output sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge sclk) begin
        if (cntNow == `ID_LAST_CLK) begin
            outCnt_r <= 4'h0;
        end else begin
            outCnt_r <= outCnt_r + 4'h1;
        end
    end

    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            idOn_r <= 1'b0;
        end else if (cntNow == `ID_LAST_CLK && !contNow) begin
            // device id, also when releasing, not when busy
            if (opcNow == `OP_RELEASE) begin
                idOn_r <= !busyHeld_r
                          && (normHeld_r || pdnHeld_r);
            end else begin
                idOn_r <= (opcNow == `OP_MFR_ID) && normHeld_r;
            end
        end
    end

    always_comb begin
        if (opcNow == `OP_MFR_ID && (outCnt_r[3] == addr_r[0])) begin
            idByte = MFR_ID;
        end else begin
            idByte = DEV_ID;
        end
    end

    // ----------------------------------------------------------------
    // link clock: quad read with wrap
    // ----------------------------------------------------------------
    always_comb begin
        wrapMask = {18'h0, wrap_r[2] & wrap_r[1],
                    wrap_r[2], wrap_r[2] | wrap_r[1], 3'h7};
        linAddr  = curAddr_r + 24'h1;
        wrapAddr = (curAddr_r & ~wrapMask) | (linAddr & wrapMask);
        curAddrNxt = curAddr_r;
        if (quadRead && qi == `QDATA_START) begin
            curAddrNxt = addr_r;
        end else if (qOn_r && nib_r) begin
            // setting applies to every quad read
            curAddrNxt = wrap_r[0] ? linAddr : wrapAddr;
        end
    end

    always_ff @(posedge sclk) begin
        curAddr_r <= curAddrNxt;
    end

    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            qOn_r <= 1'b0;
            nib_r <= 1'b0;
        end else if (quadRead && qi == `QDATA_START) begin
            qOn_r <= 1'b1;
            nib_r <= 1'b0;
        end else begin
            nib_r <= ~nib_r;
        end
    end

    wrap_page_ram u_ram (
        .wrClk  (mclk),
        .wrEn   (loadValid),
        .wrAddr (loadAddr),
        .wrData (loadData),
        .rdClk  (sclk),
        .rdAddr (curAddrNxt[7:0]),
        .rdData (rdData)
    );

    // ----------------------------------------------------------------
    // link clock: falling edge output
    // ----------------------------------------------------------------
    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            ioOut <= 4'h0;
            ioOe  <= 4'h0;
        end else if (idOn_r) begin
            ioOut <= {2'b00, idByte[~outCnt_r[2:0]], 1'b0};
            ioOe  <= 4'h2;
        end else if (qOn_r) begin
            ioOut <= nib_r ? rdData[3:0] : rdData[7:4];
            ioOe  <= 4'hf;
        end else begin
            ioOut <= 4'h0;
            ioOe  <= 4'h0;
        end
    end

    // ----------------------------------------------------------------
    // mclk: frame end detection
    // ----------------------------------------------------------------
    bit_sync #(
        .RESET_VAL (1'b1)
    ) u_cs_sync (
        .clk (mclk),
        .rst (rst),
        .d   (csN),
        .q   (csSync)
    );

    assign frameEnd = csSync && !csPrev_r && (seq_r != seenSeq_r);

    always_ff @(posedge mclk) begin
        if (rst) begin
            csPrev_r  <= 1'b1;
            seenSeq_r <= 1'b0;
        end else begin
            csPrev_r <= csSync;
            if (frameEnd) begin
                seenSeq_r <= seq_r;
            end
        end
    end

    // inputs and mode copied for the link only between frames
    always_ff @(posedge mclk) begin
        if (rst) begin
            qeHeld_r   <= 1'b0;
            busyHeld_r <= 1'b0;
            normHeld_r <= 1'b1;
            pdnHeld_r  <= 1'b0;
        end else if (csSync && csPrev_r) begin
            qeHeld_r   <= quadEnable;
            busyHeld_r <= busy;
            normHeld_r <= (pwr_r == PWR_ON);
            pdnHeld_r  <= (pwr_r == PWR_DOWN);
        end
    end

    // ----------------------------------------------------------------
    // mclk: power-down sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            pwr_r   <= PWR_ON;
            timer_r <= 10'd0;
        end else begin
            case (pwr_r)
                PWR_ON: begin
                    if (frameEnd && !contFrame_r && opc_r == `OP_DPD
                        && cnt_r == `OPC_CLKS) begin
                        pwr_r   <= PWR_ENTER;
                        timer_r <= `TDP_CYC;
                    end
                end
                PWR_ENTER: begin
                    if (timer_r <= 10'd1) begin
                        pwr_r <= PWR_DOWN;
                    end
                    timer_r <= timer_r - 10'd1;
                end
                PWR_DOWN: begin
                    if (frameEnd && !contFrame_r && opc_r == `OP_RELEASE
                        && cnt_r >= `OPC_CLKS && !busyHeld_r) begin
                        pwr_r   <= PWR_WAKE;
                        timer_r <= (cnt_r == `OPC_CLKS) ? `RELEASE_WAIT_TIME_CYC
                                                        : `RELEASE_WITH_ID_WAIT_TIME_CYC;
                    end
                end
                PWR_WAKE: begin
                    if (timer_r <= 10'd1) begin
                        pwr_r <= PWR_ON;
                    end
                    timer_r <= timer_r - 10'd1;
                end
                default: begin
                    pwr_r <= PWR_ON;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // mclk: reset enable and software reset
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            rstEn_r   <= 1'b0;
            softRst_r <= 1'b0;
        end else begin
            softRst_r <= 1'b0;
            if (frameEnd && pwr_r == PWR_ON) begin
                if (contFrame_r) begin
                    rstEn_r <= 1'b0;
                end else if (cnt_r >= `OPC_CLKS) begin
                    rstEn_r <= (opc_r == `OP_RST_EN);
                    if (opc_r == `OP_RST && rstEn_r && !contMode_r) begin
                        softRst_r <= 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // mclk: wrap setting and continuous read mode
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst || softRst_r) begin
            wrap_r <= `WRAP_DEFAULT;
        end else if (frameEnd && pwr_r == PWR_ON && qeHeld_r
                     && !contFrame_r && opc_r == `OP_WRAP
                     && cnt_r >= `WRAP_CLKS) begin
            wrap_r <= tail_r[`WRAP_HI:`WRAP_LO];
        end
    end

    // not touched by software reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            contMode_r <= 1'b0;
        end else if (frameEnd && pwr_r == PWR_ON && qeHeld_r
                     && (contFrame_r || opc_r == `OP_QUAD_READ)
                     && cnt_r >= (contFrame_r ? `OPC_CLKS
                                              : `WRAP_CLKS)) begin
            contMode_r <= (tail_r[5:4] == `CONT_KEEP);
        end
    end

    // ----------------------------------------------------------------
    // status outputs
    // ----------------------------------------------------------------
    assign softResetPulse = softRst_r;
    assign powerDown      = (pwr_r == PWR_DOWN);
    assign wrapSetting    = wrap_r;
    assign contMode       = contMode_r;
endmodule // flash_cmd_core
`default_nettype wire

// [testbench/flash_cmd_core_props.sv]
// assertion checker for the flash command interpreter
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_core_props (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       csN,
    input wire logic [3:0] ioOut,
    input wire logic [3:0] ioOe,
    input wire logic       softResetPulse,
    input wire logic       powerDown,
    input wire logic [2:0] wrapSetting,
    input wire logic       contMode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_pulse_single: assert property (
        softResetPulse |=> !softResetPulse) else $error("long reset pulse");
    chk_reset_wrap: assert property (
        softResetPulse |-> ##[0:2] wrapSetting == 3'h1)
        else $error("wrap setting kept over reset");
    chk_pd_no_reset: assert property (
        powerDown |-> !softResetPulse) else $error("reset in power-down");
    chk_cont_no_reset: assert property (
        contMode |-> !softResetPulse) else $error("reset in continuous read");
    chk_start_state: assert property (
        $fell(rst) |-> !powerDown && !contMode && wrapSetting == 3'h1)
        else $error("bad state after reset");
    chk_pd_entry_wait: assert property (
        (!powerDown && $rose(csN)) |=> !powerDown [*8])
        else $error("power-down entered too early");
    chk_idle_drive: assert property (
        (csN && $past(csN) && $past(csN, 2)) |-> ioOe == 4'h0 && ioOut == 4'h0)
        else $error("io driven while deselected");
    chk_oe_legal: assert property (
        ioOe inside {4'h0, 4'h2, 4'hf}) else $error("odd output enable");
    chk_wrap_at_idle: assert property (
        $changed(wrapSetting) |-> $past(csN, 2))
        else $error("wrap setting changed inside a frame");
endmodule // flash_cmd_core_props
bind flash_cmd_core flash_cmd_core_props chk_u (.mclk, .rst, .csN, .ioOut,
    .ioOe, .softResetPulse, .powerDown, .wrapSetting, .contMode);
`default_nettype wire

// [testbench/flash_host_model.sv]
// host controller model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
    output logic            sclk,
    output logic            csN,
    output logic      [3:0] ioIn,
    input  wire logic [3:0] ioOut,
    input  wire logic [3:0] ioOe
);
    logic [3:0] hostIo;
    logic       hostOe;
    logic [3:0] junk = 4'h5;
    // released lines show a pattern that changes every edge
    assign ioIn = (ioOut & ioOe) | (~ioOe & (hostOe ? hostIo : junk));
    always @(sclk) junk <= ~junk;
    initial begin
        sclk = 1'b0;
        csN = 1'b0;
        hostIo = 4'h0;
        hostOe = 1'b0;
        // a first rising select clears the frame, id and quad flags and the io outputs
        #1 csN = 1'b1;
    end
    // opcode serial, then address bits, then read; clock idles low
    task automatic frame(input logic [7:0] op, input int nOp, input bit quad,
                         input int nIn, input logic [47:0] din,
                         input int nOut, output logic [63:0] dout);
        logic [15:0] opx;
        opx = {op, 8'hff};
        dout = '0;
        csN = 1'b0;
        hostOe = 1'b1;
        // odd offset keeps link edges off the mclk edges
        #17;
        for (int i = 0; i < nOp + nIn; i++) begin
            if (i < nOp) hostIo = {3'b111, opx[15 - i]};
            else if (quad) hostIo = din[47 - 4 * (i - nOp) -: 4];
            else hostIo = {3'b111, din[47 - (i - nOp)]};
            #15 sclk = 1'b1;
            #15 sclk = 1'b0;
        end
        hostOe = 1'b0;
        for (int i = 0; i < nOut; i++) begin
            #15 sclk = 1'b1;
            dout = quad ? {dout[59:0], ioIn} : {dout[62:0], ioIn[1]};
            #15 sclk = 1'b0;
        end
        #15 csN = 1'b1;
    endtask
endmodule // flash_host_model
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the flash command interpreter
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] MFR = 8'ha7; // arbitrary value
    localparam logic [7:0] DEV = 8'h1e; // arbitrary value
    logic        mclk, rst, sclk, csN, quadEnable, busy, loadValid;
    logic [3:0]  ioIn, ioOut, ioOe;
    logic [7:0]  loadAddr, loadData;
    logic        softResetPulse, powerDown, contMode;
    logic [2:0]  wrapSetting;
    logic [63:0] rd;
    int          errors = 0, num_checks = 0, pulses = 0, cycles = 0;

    flash_cmd_core #(.MFR_ID(MFR), .DEV_ID(DEV)) dut_u (.mclk, .rst, .sclk,
        .csN, .ioIn, .ioOut, .ioOe, .quadEnable, .busy, .loadValid,
        .loadAddr, .loadData, .softResetPulse, .powerDown, .wrapSetting,
        .contMode);
    flash_host_model host_u (.sclk, .csN, .ioIn, .ioOut, .ioOe);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (softResetPulse === 1'b1) pulses++;
        if (cycles == 60000) begin
            errors++;
            wrap_up();
        end
    end
    // -----------------------------------------------
    // tasks
    // -----------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        num_checks++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic gap(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic cmd(input logic [7:0] op, input int nOp = 8);
        host_u.frame(op, nOp, 1'b0, 0, '0, 0, rd);
        gap(10);
    endtask
    task automatic wrap(input logic [7:0] wb);
        host_u.frame(8'h77, 8, 1'b1, 8, {24'h0, wb, 16'h0}, 0, rd);
        gap(10);
    endtask
    task automatic qread(input logic [7:0] a, input logic [7:0] m,
                         input bit op);
        host_u.frame(8'heb, op ? 8 : 0, 1'b1, 12, {16'h0, a, m, 16'h0}, 16,
                     rd);
        gap(10);
    endtask
    // page holds its own address, so eight bytes from start s
    function automatic logic [63:0] expect8(input logic [7:0] s,
                                            input int len);
        logic [63:0] r;
        logic [7:0]  m;
        r = '0;
        m = (len == 0) ? 8'hff : 8'(len - 1);
        for (int j = 0; j < 8; j++) r = {r[55:0], (s & ~m) | (8'(s + j) & m)};
        return r;
    endfunction

    initial begin
        rst = 1'b0;
        quadEnable = 1'b1;
        busy = 1'b0;
        loadValid = 1'b0;
        loadAddr = 8'h00;
        loadData = 8'h00;
        // a real rising edge so the link side reset is seen
        #1 rst = 1'b1;
        gap(8);
        rst = 1'b0;
        gap(4);
        check(64'(powerDown), 64'h0);
        check(64'(wrapSetting), 64'h1);
        for (int i = 0; i < 256; i++) begin
            loadValid = 1'b1;
            loadAddr = 8'(i);
            loadData = 8'(i);
            gap(1);
        end
        loadValid = 1'b0;
        for (int a = 0; a < 2; a++) begin
            host_u.frame(8'h90, 8, 1'b0, 24, {23'h0, a[0], 24'h0}, 32, rd);
            gap(10);
            check(rd, a ? {32'h0, DEV, MFR, DEV, MFR}
                        : {32'h0, MFR, DEV, MFR, DEV});
        end
        host_u.frame(8'hab, 8, 1'b0, 24, '0, 16, rd);
        gap(10);
        check(rd, {48'h0, DEV, DEV});
        qread(8'h7d, 8'hff, 1'b1);
        check(rd, expect8(8'h7d, 0));
        for (int k = 0; k < 4; k++) begin
            wrap(8'h8f | 8'(k << 5));
            check(64'(wrapSetting), 64'(k << 1));
            qread(8'h7d, 8'hff, 1'b1);
            check(rd, expect8(8'h7d, 8 << k));
        end
        quadEnable = 1'b0;
        wrap(8'h10);
        check(64'(wrapSetting), 64'h6);
        quadEnable = 1'b1;
        wrap(8'h70);
        qread(8'h7d, 8'hff, 1'b1);
        check(rd, expect8(8'h7d, 0));
        wrap(8'h40);
        // busy is low here, so nothing is cut by the reset
        cmd(8'h66);
        cmd(8'h99);
        check(64'(pulses), 64'h1);
        check(64'(wrapSetting), 64'h1);
        cmd(8'h66);
        cmd(8'h90);
        cmd(8'h99);
        check(64'(pulses), 64'h1);
        qread(8'h10, 8'ha0, 1'b1);
        check(64'(contMode), 64'h1);
        qread(8'h20, 8'hff, 1'b0);
        check(rd, expect8(8'h20, 0));
        check(64'(contMode), 64'h0);
        cmd(8'hb9, 9);
        gap(320);
        check(64'(powerDown), 64'h0);
        cmd(8'hb9);
        gap(250);
        check(64'(powerDown), 64'h0);
        gap(60);
        check(64'(powerDown), 64'h1);
        cmd(8'h66);
        cmd(8'h99);
        check(64'(pulses), 64'h1);
        busy = 1'b1;
        cmd(8'hab);
        gap(310);
        check(64'(powerDown), 64'h1);
        busy = 1'b0;
        cmd(8'hab);
        // still waking: the reset pair must be refused
        cmd(8'h66);
        cmd(8'h99);
        check(64'(pulses), 64'h1);
        gap(310);
        check(64'(powerDown), 64'h0);
        cmd(8'h66);
        cmd(8'h99);
        check(64'(pulses), 64'h2);
        // host puts back the setting lost to the reset
        wrap(8'h40);
        check(64'(wrapSetting), 64'h4);
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
